// ---- core/qctu_pkg.sv ----
// constants shared by the quad counter/timer unit
// assumes a single 25 MHz clock domain and a byte-wide register port
package qctu_pkg;
   // register port offsets and reset value
   localparam logic [7:0] ADDR_T3_RELOAD_LOW = 8'h92;
   localparam logic [7:0] ADDR_T3_RELOAD_HIGH = 8'h93;
   localparam logic [7:0] ADDR_T3_COUNT_LOW = 8'h94;
   localparam logic [7:0] ADDR_T3_COUNT_HIGH = 8'h95;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
   // divider ratios
   localparam int DIV_SYS12 = 12;
   localparam int DIV_SYS4 = 4;
   localparam int DIV_SYS48 = 48;
   localparam int DIV_EXT8 = 8;
   // timer 0/1 counting modes
   typedef enum logic [1:0] {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_8RELOAD = 2'h2,
      MODE_SPLIT = 2'h3
   } mode01_t;
   // prescaled clock selection for timers 0/1
   typedef enum logic [1:0] {
      PRE_SYS12 = 2'h0,
      PRE_SYS4 = 2'h1,
      PRE_SYS48 = 2'h2,
      PRE_EXT8 = 2'h3
   } prescale_t;
   // clock source for timers 2/3
   typedef enum logic [1:0] {
      SRC_SYS12 = 2'h0,
      SRC_SYS = 2'h1,
      SRC_EXT8 = 2'h2,
      SRC_NONE = 2'h3
   } src23_t;
endpackage

// ---- core/quad_counter_timer_unit.sv ----
// four 16-bit counter/timers: two legacy-style, two auto-reload
// assumes all inputs synchronous to clk; mode bits arrive as plain inputs
// Function
// - Four 16-bit counter/timers, independent except when timer 0 split mode takes over timer 1: two legacy style, two auto-reload.
// - Timers 0/1 offer 13-bit, 16-bit and 8-bit auto-reload modes; only timer 0 splits in two.
// - Timers 2/3 run as one 16-bit auto-reload timer or two 8-bit auto-reload timers.
// - Timers 0/1 pick system clock or a shared prescaled clock chosen by a two-bit field.
// - Timers 2/3 run from system clock, system clock over twelve, or external clock over eight.
// - In counter mode timers 0/1 step once per falling edge of their event pin.
// - Events up to a quarter of the system clock rate are counted.
// - Timers measure intervals and raise periodic overflow requests.
// - Timer 3 reload value sits in two readable, writable byte registers cleared at reset.
// - Timer 3 low count register is the low count byte, or the whole low 8-bit timer.
// - Timer 3 high count register is the high count byte, or the whole high 8-bit timer.
module quad_counter_timer_unit
   import qctu_pkg::*;
(
   input wire logic clk, // 25 MHz system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic [7:0] sfrAddr, // register port address
   input wire logic sfrWrite, // register write strobe
   input wire logic [7:0] sfrWriteData, // register write data
   output logic [7:0] sfrReadData, // register read data, one cycle after address
   input wire logic extOscClk, // external oscillator, sampled as a level
   input wire logic eventInputPinZero, // timer 0 event pin
   input wire logic eventInputPinOne, // timer 1 event pin
   input wire logic [1:0] timerClockSelectBits, // bit i: timer i on system clock
   input qctu_pkg::prescale_t prescaleSelectField, // shared prescaler choice
   input wire logic [1:0] counterSelect, // bit i: timer i counts pin events
   input wire logic [1:0] runEnable, // bit i: timer i runs
   input qctu_pkg::mode01_t timer0Mode, // timer 0 mode
   input qctu_pkg::mode01_t timer1Mode, // timer 1 mode
   input wire logic [15:0] timer2Reload, // timer 2 reload value
   input qctu_pkg::src23_t timer2Source, // timer 2 clock source
   input qctu_pkg::src23_t timer3Source, // timer 3 clock source
   input wire logic [1:0] splitMode, // bit i: timer 2+i split in two
   input wire logic [1:0] runLow, // bit i: timer 2+i (or its low half) runs
   input wire logic [1:0] runHigh, // bit i: high half of timer 2+i runs
   output logic [15:0] timer0Count, // timer 0 count
   output logic [15:0] timer1Count, // timer 1 count
   output logic [15:0] timer2Count, // timer 2 count
   output logic [1:0] overflow01, // bit i: timer i overflow pulse
   output logic [1:0] overflowLow, // bit i: low half of timer 2+i overflow pulse
   output logic [1:0] overflowHigh // bit i: timer 2+i (or high half) overflow pulse
);
   import qctu_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // prescalers and pin sampling
   logic [3:0] div12Count, next_div12Count;
   logic [1:0] div4Count, next_div4Count;
   logic [5:0] div48Count, next_div48Count;
   logic [2:0] ext8Count, next_ext8Count;
   logic extPrev, pin0Prev, pin1Prev;
   logic tick12, tick4, tick48, tickExt, extRise, preTick;
   logic [1:0] fallEvent;

   // edge detect on pins relies on each level standing one clock
   assign fallEvent = {pin1Prev & ~eventInputPinOne, pin0Prev & ~eventInputPinZero};
   assign extRise = extOscClk & ~extPrev;
   assign tick12 = (div12Count == 4'(DIV_SYS12 - 1));
   assign tick4 = (div4Count == 2'(DIV_SYS4 - 1));
   assign tick48 = (div48Count == 6'(DIV_SYS48 - 1));
   assign tickExt = extRise && (ext8Count == 3'(DIV_EXT8 - 1));

   // shared prescaled clock for timers 0/1
   always_comb begin
      case (prescaleSelectField)
         PRE_SYS12: preTick = tick12;
         PRE_SYS4: preTick = tick4;
         PRE_SYS48: preTick = tick48;
         default: preTick = tickExt;
      endcase
   end

   // free-running dividers
   always_comb begin
      next_div12Count = tick12 ? 4'h0 : div12Count + 4'h1;
      next_div4Count = div4Count + 2'h1;
      next_div48Count = tick48 ? 6'h00 : div48Count + 6'h01;
      next_ext8Count = extRise ? ext8Count + 3'h1 : ext8Count;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div12Count <= 4'h0;
         div4Count <= 2'h0;
         div48Count <= 6'h00;
         ext8Count <= 3'h0;
         extPrev <= 1'b0;
         pin0Prev <= 1'b0;
         pin1Prev <= 1'b0;
      end else begin
         div12Count <= next_div12Count;
         div4Count <= next_div4Count;
         div48Count <= next_div48Count;
         ext8Count <= next_ext8Count;
         extPrev <= extOscClk;
         pin0Prev <= eventInputPinZero;
         pin1Prev <= eventInputPinOne;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // timers 0 and 1

   // one step of a legacy timer; returns {overflow, count}; split mode steps low byte only
   function automatic logic [16:0] step01(input logic [15:0] c, input mode01_t m);
      logic [12:0] v13;
      v13 = {c[15:8], c[4:0]} + 13'h0001;
      case (m)
         MODE_13BIT: step01 = {&{c[15:8], c[4:0]}, v13[12:5], c[7:5], v13[4:0]};
         MODE_16BIT: step01 = {&c, c + 16'h0001};
         MODE_8RELOAD: step01 = {&c[7:0], c[15:8], (&c[7:0]) ? c[15:8] : c[7:0] + 8'h01};
         default: step01 = {&c[7:0], c[15:8], c[7:0] + 8'h01};
      endcase
   endfunction

   logic [1:0] tick01;
   logic [15:0] next_timer0Count, next_timer1Count;
   logic [1:0] next_overflow01;
   logic [16:0] step0, step1;

   // counter mode uses pin edges, otherwise system or prescaled clock
   assign tick01[0] = counterSelect[0] ? fallEvent[0] : (timerClockSelectBits[0] | preTick);
   assign tick01[1] = counterSelect[1] ? fallEvent[1] : (timerClockSelectBits[1] | preTick);
   assign step0 = step01(timer0Count, timer0Mode);
   assign step1 = step01(timer1Count, timer1Mode);

   always_comb begin
      next_timer0Count = timer0Count;
      next_timer1Count = timer1Count;
      next_overflow01 = 2'b00;
      if (runEnable[0] && tick01[0]) begin
         next_timer0Count = step0[15:0];
         next_overflow01[0] = step0[16];
      end
      // split timer 0: high byte borrows timer 1 run and flag; timer 1 then holds
      if (timer0Mode == MODE_SPLIT) begin
         if (runEnable[1] && (timerClockSelectBits[0] | preTick)) begin
            next_timer0Count[15:8] = timer0Count[15:8] + 8'h01;
            next_overflow01[1] = &timer0Count[15:8];
         end
      end else if (runEnable[1] && tick01[1] && timer1Mode != MODE_SPLIT) begin
         next_timer1Count = step1[15:0];
         next_overflow01[1] = step1[16];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer0Count <= 16'h0000;
         timer1Count <= 16'h0000;
         overflow01 <= 2'b00;
      end else begin
         timer0Count <= next_timer0Count;
         timer1Count <= next_timer1Count;
         overflow01 <= next_overflow01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // timers 2 and 3, auto-reload
   logic [15:0] count23 [2];
   logic [15:0] next_count23 [2];
   logic [15:0] reload23 [2];
   logic [1:0] tick23;
   logic [1:0] next_overflowLow, next_overflowHigh;
   logic [7:0] reloadLow, reloadHigh, next_reloadLow, next_reloadHigh;
   src23_t source23 [2];
   logic [7:0] next_sfrReadData;

   assign source23[0] = timer2Source;
   assign source23[1] = timer3Source;
   assign reload23[0] = timer2Reload;
   assign reload23[1] = {reloadHigh, reloadLow};

   for (genvar i = 0; i < 2; i++) begin : g_t23
      // clock source choice per timer
      always_comb begin
         case (source23[i])
            SRC_SYS12: tick23[i] = tick12;
            SRC_SYS: tick23[i] = 1'b1;
            SRC_EXT8: tick23[i] = tickExt;
            default: tick23[i] = 1'b0;
         endcase
      end

      // count, reload on overflow, software write wins over a tick
      always_comb begin
         next_count23[i] = count23[i];
         next_overflowLow[i] = 1'b0;
         next_overflowHigh[i] = 1'b0;
         if (tick23[i]) begin
            if (splitMode[i]) begin
               if (runLow[i]) begin
                  next_overflowLow[i] = &count23[i][7:0];
                  next_count23[i][7:0] = (&count23[i][7:0]) ? reload23[i][7:0] :
                     count23[i][7:0] + 8'h01;
               end
               if (runHigh[i]) begin
                  next_overflowHigh[i] = &count23[i][15:8];
                  next_count23[i][15:8] = (&count23[i][15:8]) ? reload23[i][15:8] :
                     count23[i][15:8] + 8'h01;
               end
            end else if (runLow[i]) begin
               next_overflowHigh[i] = &count23[i];
               next_count23[i] = (&count23[i]) ? reload23[i] : count23[i] + 16'h0001;
            end
         end
         if (i == 1 && sfrWrite && sfrAddr == ADDR_T3_COUNT_LOW) begin
            next_count23[i][7:0] = sfrWriteData;
         end
         if (i == 1 && sfrWrite && sfrAddr == ADDR_T3_COUNT_HIGH) begin
            next_count23[i][15:8] = sfrWriteData;
         end
      end

      always_ff @(posedge clk) begin
         if (sys_rst) begin
            count23[i] <= {RESET_BYTE, RESET_BYTE};
         end else begin
            count23[i] <= next_count23[i];
         end
      end
   end

   // timer 3 reload bytes and read-back of the register port
   always_comb begin
      next_reloadLow = reloadLow;
      next_reloadHigh = reloadHigh;
      if (sfrWrite && sfrAddr == ADDR_T3_RELOAD_LOW) begin
         next_reloadLow = sfrWriteData;
      end
      if (sfrWrite && sfrAddr == ADDR_T3_RELOAD_HIGH) begin
         next_reloadHigh = sfrWriteData;
      end
      if (sfrAddr == ADDR_T3_RELOAD_LOW) begin
         next_sfrReadData = reloadLow;
      end else if (sfrAddr == ADDR_T3_RELOAD_HIGH) begin
         next_sfrReadData = reloadHigh;
      end else if (sfrAddr == ADDR_T3_COUNT_LOW) begin
         next_sfrReadData = count23[1][7:0];
      end else if (sfrAddr == ADDR_T3_COUNT_HIGH) begin
         next_sfrReadData = count23[1][15:8];
      end else begin
         next_sfrReadData = UNMAPPED_BYTE;
      end
   end

   // timers stay independent except when timer 0 split mode takes over timer 1; outputs are registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reloadLow <= RESET_BYTE;
         reloadHigh <= RESET_BYTE;
         sfrReadData <= RESET_BYTE;
         timer2Count <= 16'h0000;
         overflowLow <= 2'b00;
         overflowHigh <= 2'b00;
      end else begin
         reloadLow <= next_reloadLow;
         reloadHigh <= next_reloadHigh;
         sfrReadData <= next_sfrReadData;
         timer2Count <= next_count23[0];
         overflowLow <= next_overflowLow;
         overflowHigh <= next_overflowHigh;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_reload_write: assert property (sfrWrite && sfrAddr == ADDR_T3_RELOAD_LOW |=>
      reloadLow == $past(sfrWriteData)) else $error("reload low not written");
   a_count_write: assert property (sfrWrite && sfrAddr == ADDR_T3_COUNT_HIGH |=>
      count23[1][15:8] == $past(sfrWriteData)) else $error("count high not written");
   a_read_back: assert property (sfrAddr == ADDR_T3_COUNT_LOW |=>
      sfrReadData == $past(count23[1][7:0])) else $error("count low read wrong");
   a_reload_ovf: assert property (tick23[1] && runLow[1] && !splitMode[1] && &count23[1]
      && !sfrWrite |=> count23[1] == $past(reload23[1]) && overflowHigh[1])
      else $error("timer 3 reload missed");
   a_split_low: assert property (tick23[0] && splitMode[0] && runLow[0] && !runHigh[0] |=>
      $stable(count23[0][15:8])) else $error("split high moved");
   a_event_count: assert property (counterSelect[0] && runEnable[0]
      && timer0Mode == MODE_16BIT && fallEvent[0] |=> timer0Count == $past(timer0Count) + 16'h1)
      else $error("event not counted");
   a_pin_quiet: assert property (counterSelect[0] && timer0Mode == MODE_16BIT
      && !fallEvent[0] |=> $stable(timer0Count)) else $error("count without event");
   a_div_twelve: assert property (tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
      else $error("divide by twelve wrong");
   a_mode13_wrap: assert property (runEnable[1] && tick01[1] && timer1Mode == MODE_13BIT
      && timer0Mode != MODE_SPLIT && timer1Count[4:0] == 5'h1f |=> timer1Count[4:0] == 5'h00)
      else $error("13-bit low field wrong");
   c_t3_overflow: cover property (overflowHigh[1]);
   c_split_both: cover property (overflowLow[1] && overflowHigh[1]);
   c_event_ovf: cover property (counterSelect[0] && overflow01[0]);
endmodule

// ---- dv/event_pin_model.sv ----
// event source standing on the two counter input pins of the timer unit
// assumes the bench calls emit(); pins idle high and change on falling clk
module event_pin_model
(
   input wire logic clk, // system clock
   output logic pinZero, // event line for timer 0
   output logic pinOne // event line for timer 1
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////
   // idle high, so the first low step is a real falling edge
   initial begin
      pinZero = 1'b1;
      pinOne = 1'b1;
   end
   ////////////////////////////////////////
   // one low then high event on the chosen pins
   task automatic emit(input logic [1:0] which, input int hold);
      int h;
      // never under two cycles a level, holding events to a quarter of the clock rate
      h = (hold < 2) ? 2 : hold;
      @(negedge clk);
      {pinOne, pinZero} = ~which;
      repeat (h) @(negedge clk);
      {pinOne, pinZero} = 2'b11;
      repeat (h - 1) @(negedge clk);
   endtask
endmodule

// ---- dv/quad_counter_timer_unit_tb.sv ----
// self-checking bench for the quad counter/timer unit
// assumes inputs change on falling clk; windows are whole multiples of a tick
module quad_counter_timer_unit_tb
   import qctu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, sfrWrite, extOscClk, pinZero, pinOne;
   logic [7:0] sfrAddr, sfrWriteData, sfrReadData;
   logic [1:0] timerClockSelectBits, counterSelect, runEnable, splitMode, runLow, runHigh;
   logic [1:0] overflow01, overflowLow, overflowHigh;
   logic [15:0] timer2Reload, timer0Count, timer1Count, timer2Count;
   prescale_t prescaleSelectField;
   mode01_t timer0Mode, timer1Mode;
   src23_t timer2Source, timer3Source;
   int errTotal = 0;
   int nChecks = 0;
   int ovLow2 = 0;
   int ovLow3 = 0;
   int ovHigh3 = 0;
   int ov01 = 0;
   ////////////////////////////////////////
   quad_counter_timer_unit quad_counter_timer_unit_i (.clk(clk), .sys_rst(sys_rst),
      .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWriteData(sfrWriteData),
      .sfrReadData(sfrReadData), .extOscClk(extOscClk), .eventInputPinZero(pinZero),
      .eventInputPinOne(pinOne), .timerClockSelectBits(timerClockSelectBits),
      .prescaleSelectField(prescaleSelectField), .counterSelect(counterSelect),
      .runEnable(runEnable), .timer0Mode(timer0Mode), .timer1Mode(timer1Mode),
      .timer2Reload(timer2Reload), .timer2Source(timer2Source),
      .timer3Source(timer3Source), .splitMode(splitMode), .runLow(runLow),
      .runHigh(runHigh), .timer0Count(timer0Count), .timer1Count(timer1Count),
      .timer2Count(timer2Count), .overflow01(overflow01), .overflowLow(overflowLow),
      .overflowHigh(overflowHigh));
   event_pin_model event_pin_model_i (.clk(clk), .pinZero(pinZero), .pinOne(pinOne));
   ////////////////////////////////////////
   // clock, and an oscillator with a rising edge every fourth clk
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always begin
      repeat (2) @(negedge clk);
      extOscClk = ~extOscClk;
   end
   // overflow pulses last one cycle; tally mid-cycle, away from the launching edge
   always @(negedge clk) begin
      if (overflow01[1] === 1'b1) ov01++;
      if (overflowLow[0] === 1'b1) ovLow2++;
      if (overflowLow[1] === 1'b1) ovLow3++;
      if (overflowHigh[1] === 1'b1) ovHigh3++;
   end
   ////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp) begin
         errTotal++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      sfrAddr = addr;
      sfrWriteData = data;
      sfrWrite = 1'b1;
      @(negedge clk);
      sfrWrite = 1'b0;
   endtask
   // read data is registered: present the address, take it one edge later
   task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp);
      @(negedge clk);
      sfrAddr = addr;
      @(negedge clk);
      check({8'h00, sfrReadData}, {8'h00, exp});
   endtask
   task automatic summarize;
      if (errTotal == 0 && nChecks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // watchdog: the sequence needs under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      errTotal++;
      summarize();
   end
   ////////////////////////////////////////
   initial begin
      logic [15:0] b0, b1;
      logic [12:0] v;
      int o1, o2, w;
      int divs[4];
      logic [7:0] lo;
      // one ext/8 tick is eight oscillator rises, each four clk apart
      divs = '{DIV_SYS12, DIV_SYS4, DIV_SYS48, 4 * DIV_EXT8};
      {sys_rst, sfrWrite, extOscClk, sfrAddr, sfrWriteData} = {3'b100, 16'h0000};
      {timerClockSelectBits, counterSelect, runEnable, splitMode, runLow, runHigh} = '0;
      prescaleSelectField = PRE_SYS12;
      timer0Mode = MODE_16BIT;
      timer1Mode = MODE_16BIT;
      timer2Reload = 16'h0000;
      timer2Source = SRC_NONE;
      timer3Source = SRC_NONE;
      // two rising edges under reset, then release off the edge
      repeat (2) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      // reset values, unmapped read and ignored unmapped write
      regWrite(8'h90, 8'ha5);
      for (int a = 8'h92; a <= 8'h95; a++) readCheck(8'(a), 8'h00);
      readCheck(8'h96, 8'h00);
      // timer 3 as one 16-bit timer, two ticks before wrap
      regWrite(8'h92, 8'h34);
      regWrite(8'h93, 8'h12);
      regWrite(8'h94, 8'hfe);
      regWrite(8'h95, 8'hff);
      readCheck(8'h92, 8'h34);
      readCheck(8'h93, 8'h12);
      readCheck(8'h94, 8'hfe);
      readCheck(8'h95, 8'hff);
      timer3Source = SRC_SYS;
      o1 = ovHigh3;
      runLow = 2'b10;
      repeat (2) @(negedge clk);
      runLow = 2'b00;
      readCheck(8'h94, 8'h34);
      readCheck(8'h95, 8'h12);
      check(16'(ovHigh3 - o1), 16'h0001);
      // timer 3 split: both halves wrap on different ticks
      splitMode = 2'b10;
      regWrite(8'h92, 8'h10);
      regWrite(8'h93, 8'h20);
      regWrite(8'h94, 8'hff);
      regWrite(8'h95, 8'hfe);
      {o1, o2} = {ovLow3, ovHigh3};
      {runLow, runHigh} = 4'b1010;
      repeat (2) @(negedge clk);
      {runLow, runHigh} = 4'b0000;
      readCheck(8'h94, 8'h11);
      readCheck(8'h95, 8'h20);
      check(16'(ovLow3 - o1), 16'h0001);
      check(16'(ovHigh3 - o2), 16'h0001);
      // timer 2 on clk/12 then ext/8, then split low half to its wrap
      timer2Source = SRC_SYS12;
      runLow = 2'b01;
      repeat (120) @(negedge clk);
      timer2Source = SRC_EXT8;
      repeat (64) @(negedge clk);
      check(timer2Count, 16'h000c);
      timer2Source = SRC_SYS;
      splitMode = 2'b01;
      timer2Reload = 16'h4477;
      o1 = ovLow2;
      repeat (244) @(negedge clk);
      runLow = 2'b00;
      @(negedge clk);
      check(timer2Count, 16'h0077);
      check(16'(ovLow2 - o1), 16'h0001);
      // timers 0/1 on every prescaled choice: ten ticks a window
      for (int p = 0; p < 4; p++) begin
         prescaleSelectField = prescale_t'(p);
         b0 = timer0Count;
         b1 = timer1Count;
         runEnable = 2'b11;
         repeat (10 * divs[p]) @(negedge clk);
         runEnable = 2'b00;
         check(timer0Count - b0, 16'd10);
         check(timer1Count - b1, 16'd10);
      end
      {timerClockSelectBits, b0, b1, runEnable} = {2'b11, timer0Count, timer1Count, 2'b11};
      repeat (7) @(negedge clk);
      runEnable = 2'b00;
      check(timer0Count - b0, 16'd7);
      check(timer1Count - b1, 16'd7);
      // counter mode at a quarter of the clock rate
      {counterSelect, b0, b1, runEnable} = {2'b11, timer0Count, timer1Count, 2'b11};
      repeat (5) event_pin_model_i.emit(2'b11, 2);
      repeat (3) @(negedge clk);
      {counterSelect, runEnable} = 4'b0000;
      check(timer0Count - b0, 16'd5);
      check(timer1Count - b1, 16'd5);
      // timer 0 split in two: timer 1 must hold
      timer0Mode = MODE_SPLIT;
      b0 = timer0Count;
      b1 = timer1Count;
      runEnable = 2'b11;
      repeat (6) @(negedge clk);
      runEnable = 2'b00;
      check(timer1Count - b1, 16'd0);
      check({8'(timer0Count[15:8] - b0[15:8]), 8'(timer0Count[7:0] - b0[7:0])}, 16'h0606);
      // 13-bit mode on both: bits 7:5 hold, carry goes from bit 4 to bit 8
      timer0Mode = MODE_13BIT;
      timer1Mode = MODE_13BIT;
      b0 = timer0Count;
      b1 = timer1Count;
      runEnable = 2'b11;
      repeat (40) @(negedge clk);
      runEnable = 2'b00;
      v = {b0[15:8], b0[4:0]} + 13'd40;
      check(timer0Count, {v[12:5], b0[7:5], v[4:0]});
      v = {b1[15:8], b1[4:0]} + 13'd40;
      check(timer1Count, {v[12:5], b1[7:5], v[4:0]});
      // timer 1 as 8-bit auto-reload: low byte reloads from high byte on wrap
      timer1Mode = MODE_8RELOAD;
      b1 = timer1Count;
      o1 = ov01;
      runEnable = 2'b10;
      repeat (300) @(negedge clk);
      runEnable = 2'b00;
      @(negedge clk);
      lo = b1[7:0];
      w = 0;
      repeat (300) begin
         if (lo == 8'hff) begin
            lo = b1[15:8];
            w++;
         end else begin
            lo = lo + 8'h01;
         end
      end
      check(timer1Count, {b1[15:8], lo});
      check(16'(ov01 - o1), 16'(w));
      summarize();
   end
endmodule
